// ---- include/abt_pkg.sv ----
// Package for the asynchronous bus cycle termination decoder.
// Assumes a single 100 MHz clock and asynchronous active-high reset.
package abt_pkg;

   // ----------------------------------------------------------------
   // Outcome encoding
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ABT_NONE,
      ABT_NORMAL,
      ABT_HALT,
      ABT_BUS_ERR,
      ABT_RETRY
   } abt_outcome_t;

   // ----------------------------------------------------------------
   // Synchronised termination inputs
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] size_ack;
      logic       bus_error;
      logic       halt;
   } abt_term_t;

   // ----------------------------------------------------------------
   // Cycle access information kept for a retry
   // ----------------------------------------------------------------
   localparam int ABT_ADDR_W = 32;
   localparam int ABT_FC_W   = 3;
   localparam int ABT_SIZE_W = 2;

   typedef struct packed {
      logic [ABT_ADDR_W-1:0] addr;
      logic [ABT_FC_W-1:0]   fc;
      logic [ABT_SIZE_W-1:0] size;
      logic                  rd;
      logic                  prefetch;
      logic                  cache_fill;
   } abt_access_t;

   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   localparam int        ABT_CLK_NS     = 10;
   localparam int        ABT_RESYNC_NS  = 20;
   localparam logic [3:0] ABT_RESYNC_CYC = 4'(ABT_RESYNC_NS / ABT_CLK_NS);
   localparam logic [3:0] ABT_RESET_CNT  = 4'h0;

endpackage : abt_pkg

// ---- rtl/abt_sync.sv ----
// Two flip-flop synchroniser for the asynchronous termination pins.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps
module abt_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta;

   if (W < 1) begin : g_w_check
      $error("abt_sync: width must be positive");
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : abt_sync

// ---- rtl/abt_term.sv ----
// Bus cycle termination decoder and retry sequencer.
// Assumes the bus controller issues cycles with start_cycle and
// that termination pins are active-high and asynchronous to clk.
`timescale 1ns/1ps
// Behaviour
// - Acknowledge alone ends the cycle normally and continues.
// - Halt by acknowledge time: complete normally, then stall until halt drops.
// - Bus error without halt, before or with acknowledge: terminate, bus error.
// - Bus error one even state after acknowledge: still a bus error.
// - Bus error with halt: terminate and retry once bus error and halt both drop.
// - Late bus error with halt after acknowledge: terminate and retry.
// - Bus error wins over a simultaneous acknowledge.
// - Prefetch bus error deferred until used; dropped on flush.
// - Bus error recognised up to two clocks (one even state) after acknowledge, or during cycle.
// - Bus error closes the cycle normally before exception handling.
// - Bus error on a cache fill read invalidates that entry.
// - Inputs evaluated at even states in ST_WAIT and ST_LATE, on every clock otherwise; state n compared with n+2.
// - Retry: drop strobes, wait for release, resync, reissue same access.
module abt_term (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 start_cycle,
   input  wire abt_pkg::abt_access_t access_in,
   input  wire logic [1:0]           size_ack_pair,
   input  wire logic                 bus_error_in,
   input  wire logic                 halt_in,
   input  wire logic                 prefetch_used,
   input  wire logic                 prefetch_flush,
   output logic                      address_strobe_out,
   output abt_pkg::abt_access_t      access_out,
   output logic                      busy,
   output logic                      cycle_done,
   output abt_pkg::abt_outcome_t     outcome,
   output logic                      bus_halted,
   output logic                      bus_err_exc,
   output logic                      cache_invalidate
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT,
      ST_LATE,
      ST_HALTED,
      ST_RETRY_WAIT,
      ST_RESYNC
   } abt_state_t;

   abt_pkg::abt_term_t    term;
   abt_state_t            state;
   abt_state_t            next_state;
   abt_pkg::abt_access_t  next_access_out;
   logic                  next_as;
   logic                  next_done;
   abt_pkg::abt_outcome_t next_outcome;
   logic                  next_err_exc;
   logic                  next_inval;
   logic [3:0]            cnt;
   logic [3:0]            next_cnt;
   logic                  pend_err;
   logic                  next_pend_err;
   logic                  even;
   logic                  next_even;
   logic                  ack;

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   abt_sync #(.W(4)) abt_sync_i (
      .clk  (clk),
      .rst  (rst),
      .din  ({size_ack_pair, bus_error_in, halt_in}),
      .dout (term)
   );

   assign ack        = |term.size_ack;
   assign busy       = (state != ST_IDLE);
   assign bus_halted = (state == ST_HALTED);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_state      = state;
      next_access_out = access_out;
      next_as         = address_strobe_out;
      next_done       = 1'b0;
      next_outcome    = outcome;
      next_err_exc    = 1'b0;
      next_inval      = 1'b0;
      next_cnt        = cnt;
      next_pend_err   = pend_err;
      // Even bus states fall on every other clock of an active cycle
      next_even       = busy ? ~even : 1'b0;
      // Clear first so that a new prefetch error in the same cycle wins
      if (pend_err && prefetch_flush) begin
         next_pend_err = 1'b0;
      end else if (pend_err && prefetch_used) begin
         next_pend_err = 1'b0;
         next_err_exc  = 1'b1;
      end
      unique case (state)
         ST_IDLE: begin
            if (start_cycle) begin
               next_state      = ST_WAIT;
               next_access_out = access_in;
               next_as         = 1'b1;
               next_outcome    = abt_pkg::ABT_NONE;
            end
         end
         ST_WAIT: begin
            if (even) begin
               if (term.bus_error) begin
                  // Bus error ends the cycle the ordinary way first
                  next_as   = 1'b0;
                  next_done = 1'b1;
                  if (term.halt) begin
                     next_outcome = abt_pkg::ABT_RETRY;
                     next_state   = ST_RETRY_WAIT;
                  end else begin
                     next_outcome = abt_pkg::ABT_BUS_ERR;
                     next_state   = ST_IDLE;
                     next_inval   = access_out.cache_fill & access_out.rd;
                     if (access_out.prefetch) next_pend_err = 1'b1;
                     else next_err_exc = 1'b1;
                  end
               end else if (ack && term.halt) begin
                  next_as      = 1'b0;
                  next_done    = 1'b1;
                  next_outcome = abt_pkg::ABT_HALT;
                  next_state   = ST_HALTED;
               end else if (ack) begin
                  // Hold the verdict for one even state to catch a late error
                  next_as    = 1'b0;
                  next_state = ST_LATE;
               end
            end
         end
         ST_LATE: begin
            if (even) begin
               next_done = 1'b1;
               if (term.bus_error && term.halt) begin
                  next_outcome = abt_pkg::ABT_RETRY;
                  next_state   = ST_RETRY_WAIT;
               end else if (term.bus_error) begin
                  next_outcome = abt_pkg::ABT_BUS_ERR;
                  next_state   = ST_IDLE;
                  next_inval   = access_out.cache_fill & access_out.rd;
                  if (access_out.prefetch) next_pend_err = 1'b1;
                  else next_err_exc = 1'b1;
               end else begin
                  next_outcome = abt_pkg::ABT_NORMAL;
                  next_state   = ST_IDLE;
               end
            end
         end
         ST_HALTED: begin
            if (!term.halt) next_state = ST_IDLE;
         end
         ST_RETRY_WAIT: begin
            if (!term.bus_error && !term.halt) begin
               next_state = ST_RESYNC;
               next_cnt   = abt_pkg::ABT_RESYNC_CYC;
            end
         end
         ST_RESYNC: begin
            if (cnt <= 4'h1) begin
               next_state = ST_WAIT;
               next_as    = 1'b1;
               next_cnt   = abt_pkg::ABT_RESET_CNT;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state              <= ST_IDLE;
         access_out         <= '0;
         address_strobe_out <= 1'b0;
         cycle_done         <= 1'b0;
         outcome            <= abt_pkg::ABT_NONE;
         bus_err_exc        <= 1'b0;
         cache_invalidate   <= 1'b0;
         cnt                <= abt_pkg::ABT_RESET_CNT;
         pend_err           <= 1'b0;
         even               <= 1'b0;
      end else begin
         state              <= next_state;
         access_out         <= next_access_out;
         address_strobe_out <= next_as;
         cycle_done         <= next_done;
         outcome            <= next_outcome;
         bus_err_exc        <= next_err_exc;
         cache_invalidate   <= next_inval;
         cnt                <= next_cnt;
         pend_err           <= next_pend_err;
         even               <= next_even;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_ack_late;
      state == ST_WAIT && even && ack && !term.bus_error && !term.halt;
   endsequence

   property p_normal;
      @(posedge clk) disable iff (rst)
      s_ack_late ##2 (!term.bus_error) |=> outcome == abt_pkg::ABT_NORMAL && cycle_done;
   endproperty
   a_normal: assert property (p_normal) else $error("normal end missed");

   property p_halt;
      @(posedge clk) disable iff (rst)
      (state == ST_WAIT && even && ack && term.halt && !term.bus_error)
      |=> bus_halted && outcome == abt_pkg::ABT_HALT;
   endproperty
   a_halt: assert property (p_halt) else $error("halt end missed");

   property p_bus_error_in;
      @(posedge clk) disable iff (rst)
      (state == ST_WAIT && even && term.bus_error && !term.halt)
      |=> outcome == abt_pkg::ABT_BUS_ERR && !address_strobe_out;
   endproperty
   a_bus_error_in: assert property (p_bus_error_in) else $error("bus error missed");

   property p_late_bus_error_in;
      @(posedge clk) disable iff (rst)
      s_ack_late ##2 (term.bus_error && !term.halt) |=> outcome == abt_pkg::ABT_BUS_ERR;
   endproperty
   a_late_bus_error_in: assert property (p_late_bus_error_in) else $error("late error missed");

   property p_retry;
      @(posedge clk) disable iff (rst)
      (state == ST_WAIT && even && term.bus_error && term.halt)
      |=> outcome == abt_pkg::ABT_RETRY && !address_strobe_out;
   endproperty
   a_retry: assert property (p_retry) else $error("retry missed");

   property p_late_retry;
      @(posedge clk) disable iff (rst)
      s_ack_late ##2 (term.bus_error && term.halt) |=> outcome == abt_pkg::ABT_RETRY;
   endproperty
   a_late_retry: assert property (p_late_retry) else $error("late retry missed");

   property p_prio;
      @(posedge clk) disable iff (rst)
      (state == ST_WAIT && even && ack && term.bus_error)
      |=> outcome != abt_pkg::ABT_NORMAL && outcome != abt_pkg::ABT_HALT;
   endproperty
   a_prio: assert property (p_prio) else $error("acknowledge beat bus error");

   property p_defer;
      @(posedge clk) disable iff (rst)
      (state == ST_IDLE && pend_err && prefetch_flush) |=> !bus_err_exc && !pend_err;
   endproperty
   a_defer: assert property (p_defer) else $error("flushed prefetch error taken");

   property p_inval;
      @(posedge clk) disable iff (rst)
      $rose(cache_invalidate)
      |-> outcome == abt_pkg::ABT_BUS_ERR && access_out.cache_fill && access_out.rd;
   endproperty
   a_inval: assert property (p_inval) else $error("stray cache invalidate");

   property p_resync;
      @(posedge clk) disable iff (rst)
      (state == ST_RETRY_WAIT && !term.bus_error && !term.halt)
      |=> !address_strobe_out ##1 !address_strobe_out ##[1:4] address_strobe_out;
   endproperty
   a_resync: assert property (p_resync) else $error("retry not reissued");

endmodule : abt_term

// ---- test/abt_far_end.sv ----
// Model of the external termination logic facing the decoder.
// Assumes the bench sets the response mode before each cycle starts.
`timescale 1ns/1ps
module abt_far_end (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       address_strobe_out,
   input  wire logic [2:0] mode,
   input  wire logic [1:0] ack_val,
   output logic      [1:0] size_ack_pair,
   output logic            bus_error_in,
   output logic            halt_in
);
   // Modes: 0 ack, 1 halt+ack, 2 no answer, 3 error+ack, 4 ack then error,
   // 5 error+halt, 6 ack then error+halt on the next clock
   logic [3:0] step;
   logic [3:0] low_cnt;
   logic [3:0] dly;
   logic       active;
   logic       strobe_q;

   // Unanswered accesses are given a long timeout before the error
   assign dly = (mode == 3'h2) ? 4'h8 : 4'h1;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {size_ack_pair, bus_error_in, halt_in} <= '0;
         {step, low_cnt, active, strobe_q}      <= '0;
      end else begin
         strobe_q <= address_strobe_out;
         if (address_strobe_out && !strobe_q) begin
            active  <= 1'b1;
            step    <= 4'h0;
            low_cnt <= 4'h0;
         end else if (active) begin
            if (step != 4'hf) step <= step + 4'h1;
            if (step == dly) begin
               if (mode != 3'h2 && mode != 3'h5) size_ack_pair <= ack_val;
               if (mode == 3'h2 || mode == 3'h3 || mode == 3'h5) bus_error_in <= 1'b1;
               if (mode == 3'h1 || mode == 3'h5) halt_in <= 1'b1;
            end
            if (step == dly + 4'h1 && (mode == 3'h4 || mode == 3'h6)) begin
               bus_error_in <= 1'b1;
               halt_in      <= (mode == 3'h6);
            end
            // Release only once the strobe is down, never into the next cycle
            if (!address_strobe_out && step > dly + 4'h1) begin
               size_ack_pair <= 2'h0;
               bus_error_in  <= 1'b0;
               low_cnt       <= low_cnt + 4'h1;
               if (low_cnt == 4'h6) begin
                  halt_in <= 1'b0;
                  active  <= 1'b0;
               end
            end
         end
      end
   end
endmodule : abt_far_end

// ---- test/abt_term_tb_top.sv ----
// Self-checking bench for the bus cycle termination decoder.
// Assumes the far-end model drives every termination pin.
`timescale 1ns/1ps
module abt_term_tb_top;
   logic                  clk, rst, start_cycle, prefetch_used, prefetch_flush;
   logic                  bus_error_in, halt_in, address_strobe_out, busy, cycle_done;
   logic                  bus_halted, bus_err_exc, cache_invalidate, strobe_q;
   logic [1:0]            size_ack_pair, ack_val;
   logic [2:0]            mode;
   abt_pkg::abt_access_t  access_in, access_out;
   abt_pkg::abt_outcome_t outcome;
   int                    num_errors, comparisons, exc_cnt, inval_cnt, rise_cnt;

   abt_term abt_term_i (.clk(clk), .rst(rst), .start_cycle(start_cycle),
      .access_in(access_in), .size_ack_pair(size_ack_pair), .bus_error_in(bus_error_in),
      .halt_in(halt_in), .prefetch_used(prefetch_used), .prefetch_flush(prefetch_flush),
      .address_strobe_out(address_strobe_out), .access_out(access_out), .busy(busy),
      .cycle_done(cycle_done), .outcome(outcome), .bus_halted(bus_halted),
      .bus_err_exc(bus_err_exc), .cache_invalidate(cache_invalidate));
   abt_far_end abt_far_end_i (.clk(clk), .rst(rst), .address_strobe_out(address_strobe_out),
      .mode(mode), .ack_val(ack_val), .size_ack_pair(size_ack_pair),
      .bus_error_in(bus_error_in), .halt_in(halt_in));

   always #5 clk = ~clk;

   // Pulse and strobe counters, sampled away from the launching edge
   always @(negedge clk) begin
      if (bus_err_exc === 1'b1) exc_cnt++;
      if (cache_invalidate === 1'b1) inval_cnt++;
      if (address_strobe_out === 1'b1 && strobe_q !== 1'b1) rise_cnt++;
      strobe_q = address_strobe_out;
   end

   task automatic fail(input string msg);
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
   endtask : fail
   task automatic chk_out(input abt_pkg::abt_outcome_t got, input abt_pkg::abt_outcome_t exp);
      comparisons++;
      if (got !== exp) fail($sformatf("outcome %0d, expected %0d", got, exp));
   endtask : chk_out
   task automatic chk_bit(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) fail($sformatf("%s is %b, expected %b", what, got, exp));
   endtask : chk_bit
   task automatic chk_cnt(input int got, input int exp, input string what);
      comparisons++;
      if (got != exp) fail($sformatf("%s count %0d, expected %0d", what, got, exp));
   endtask : chk_cnt
   task automatic chk_acc(input abt_pkg::abt_access_t got, input abt_pkg::abt_access_t exp);
      comparisons++;
      if (got !== exp) fail("access of reissued cycle differs");
   endtask : chk_acc
   task automatic close_out();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   function automatic abt_pkg::abt_access_t mk(input logic [31:0] ad, input logic pf,
                                              input logic cf);
      abt_pkg::abt_access_t v;
      v            = '0;
      v.addr       = ad;
      v.fc         = 3'h5;
      v.size       = 2'h2;
      v.rd         = 1'b1;
      v.prefetch   = pf;
      v.cache_fill = cf;
      return v;
   endfunction : mk

   // -----------------------------------------------------------------
   // Cycle helpers
   // -----------------------------------------------------------------
   task automatic start_cyc(input logic [2:0] m, input logic [1:0] a,
                            input abt_pkg::abt_access_t acc);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 80) begin
         @(negedge clk);
         n++;
      end
      if (n == 80) fail("still busy");
      @(posedge clk);
      mode        <= m;
      ack_val     <= a;
      access_in   <= acc;
      start_cycle <= 1'b1;
      @(posedge clk);
      start_cycle <= 1'b0;
   endtask : start_cyc
   task automatic wait_done(input abt_pkg::abt_outcome_t exp);
      int n;
      n = 0;
      @(negedge clk);
      while (cycle_done !== 1'b1 && n < 80) begin
         @(negedge clk);
         n++;
      end
      chk_bit(cycle_done, 1'b1, "done");
      chk_bit(address_strobe_out, 1'b0, "strobe at end");
      chk_out(outcome, exp);
   endtask : wait_done

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_normal();
      for (int i = 1; i < 4; i++) begin
         start_cyc(3'h0, 2'(i), mk(32'h0000_1000 + 32'(i), 1'b0, 1'b0));
         wait_done(abt_pkg::ABT_NORMAL);
         chk_bit(busy, 1'b0, "busy after end");
      end
      chk_cnt(exc_cnt, 0, "exception");
   endtask : t_normal
   task automatic t_halt();
      int n;
      n = 0;
      start_cyc(3'h1, 2'h3, mk(32'h0000_1100, 1'b0, 1'b0));
      wait_done(abt_pkg::ABT_HALT);
      @(negedge clk);
      chk_bit(bus_halted, 1'b1, "halted");
      while (bus_halted !== 1'b0 && n < 40) begin
         chk_bit(address_strobe_out, 1'b0, "strobe while halted");
         @(negedge clk);
         n++;
      end
      chk_bit(bus_halted, 1'b0, "halted after release");
   endtask : t_halt
   task automatic t_error(input logic [2:0] m, input logic cf);
      int e;
      int v;
      e = exc_cnt;
      v = inval_cnt;
      start_cyc(m, 2'h1, mk(32'h0000_2000, 1'b0, cf));
      wait_done(abt_pkg::ABT_BUS_ERR);
      repeat (3) @(negedge clk);
      chk_cnt(exc_cnt, e + 1, "exception");
      chk_cnt(inval_cnt, v + int'(cf), "invalidate");
   endtask : t_error
   task automatic t_retry(input logic [2:0] m);
      abt_pkg::abt_access_t acc;
      int r;
      int e;
      acc = mk(32'h0000_4000 + 32'(m), 1'b0, 1'b0);
      r   = rise_cnt;
      e   = exc_cnt;
      start_cyc(m, 2'h1, acc);
      wait_done(abt_pkg::ABT_RETRY);
      @(posedge clk);
      mode <= 3'h0;
      wait_done(abt_pkg::ABT_NORMAL);
      chk_acc(access_out, acc);
      chk_cnt(rise_cnt, r + 2, "strobe");
      chk_cnt(exc_cnt, e, "exception");
   endtask : t_retry
   task automatic t_prefetch(input logic flush);
      int e;
      e = exc_cnt;
      start_cyc(3'h3, 2'h1, mk(32'h0000_5000, 1'b1, 1'b0));
      wait_done(abt_pkg::ABT_BUS_ERR);
      repeat (3) @(negedge clk);
      chk_cnt(exc_cnt, e, "deferred");
      @(posedge clk);
      prefetch_used  <= 1'b1;
      prefetch_flush <= flush;
      @(posedge clk);
      prefetch_used  <= 1'b0;
      prefetch_flush <= 1'b0;
      repeat (3) @(negedge clk);
      chk_cnt(exc_cnt, e + int'(!flush), "prefetch");
   endtask : t_prefetch

   initial begin
      watchdog_loop : begin
         repeat (5000) @(posedge clk);
         fail("run did not finish in time");
         close_out();
      end
   end

   initial begin
      {clk, start_cycle, prefetch_used, prefetch_flush} = '0;
      {mode, ack_val, access_in}                        = '0;
      {num_errors, comparisons, exc_cnt, inval_cnt, rise_cnt} = '0;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_normal();
      t_halt();
      t_error(3'h3, 1'b1);
      t_error(3'h2, 1'b0);
      t_error(3'h4, 1'b0);
      t_retry(3'h5);
      t_retry(3'h6);
      t_prefetch(1'b0);
      t_prefetch(1'b1);
      close_out();
   end
endmodule : abt_term_tb_top
